/* File: dv/blf_host_model.sv */
/*
 * blf_host_model: host side that watches the shutdown warning flag and irq line.
 * assumes the flag logic runs on the same reference clock and reset.
 */
`timescale 1ns/1ps
module blf_host_model (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic charge_state_irq_i,
  input wire logic shutdown_warning_flag_i,
  output logic [7:0] irq_count_o,
  output logic flag_at_irq_o
);
  // count each irq pulse and latch the flag seen with it; the host reads
  // the flag only on an interrupt, so a missed pulse hides a transition
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      irq_count_o <= 8'h00;
      flag_at_irq_o <= 1'b0;
    end else if (charge_state_irq_i) begin
      irq_count_o <= irq_count_o + 8'h01;
      flag_at_irq_o <= shutdown_warning_flag_i;
    end
  end
endmodule

/* File: dv/test_blf_flag_logic.sv */
/*
 * test_blf_flag_logic: self-checking bench for the flag logic.
 * assumes flags and irq change one edge after the take, the pin two.
 */
`timescale 1ns/1ps
`define CHK(a, b, m) begin samples_checked++; if ((a) !== (b)) begin \
  errors++; $display("unexpected at %0t: %s", $time, m); end end
module test_blf_flag_logic;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic meas_valid_i = 1'b0;
  logic [15:0] left_i = 16'h0000, volt_i = 16'h0000, full_i = 16'h0000;
  logic [15:0] cap_thr_i = 16'h0064, set_v_i = 16'h0bb8;
  logic [15:0] clr_v_i = 16'h0ce4, final_v_i = 16'h0af0;
  logic low_pin_enable_i = 1'b1;
  logic sense_valid_i = 1'b0;
  logic signed [15:0] sense_i = 16'sh0000;
  logic cal_write_i = 1'b0, cal_select_i = 1'b0;
  logic [31:0] cal_word_i = 32'h00000000;
  logic cap_flag, sd_flag, pin, irq, soc_zero, flag_at_irq;
  logic [15:0] full_o;
  logic [31:0] est_o, gain_o, delta_o;
  logic [7:0] irq_count;
  int errors = 0;
  int samples_checked = 0;

  // 40 mhz reference clock
  always #12.5 ref_clk_i = ~ref_clk_i;

  blf_flag_logic u_blf_flag_logic (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .meas_valid_i(meas_valid_i), .left_charge_value_i(left_i),
    .cell_voltage_i(volt_i), .full_cell_estimate_i(full_i),
    .capacity_low_threshold_i(cap_thr_i), .shutdown_set_voltage_i(set_v_i),
    .shutdown_clear_voltage_i(clr_v_i), .final_voltage_i(final_v_i),
    .low_pin_enable_i(low_pin_enable_i), .sense_valid_i(sense_valid_i),
    .sense_i(sense_i), .cal_write_i(cal_write_i),
    .cal_select_i(cal_select_i), .cal_word_i(cal_word_i),
    .capacity_low_flag_o(cap_flag), .shutdown_warning_flag_o(sd_flag),
    .low_battery_pin_o(pin), .charge_state_irq_o(irq),
    .soc_zero_o(soc_zero), .full_cell_charge_value_o(full_o),
    .charge_estimate_o(est_o), .coulomb_gain_cal_o(gain_o),
    .coulomb_delta_cal_o(delta_o));

  blf_host_model u_blf_host_model (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .charge_state_irq_i(irq), .shutdown_warning_flag_i(sd_flag),
    .irq_count_o(irq_count), .flag_at_irq_o(flag_at_irq));

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // one measurement: flags and the one-cycle irq are seen one edge after
  // the take, the pin one edge later; next take 3 cycles after this one
  task automatic meas(input logic [15:0] cap, input logic [15:0] v,
                      input logic ec, input logic es, input logic ei,
                      input logic ez);
    left_i = cap;
    volt_i = v;
    full_i = cap + 16'h03e8;
    meas_valid_i = 1'b1;
    @(negedge ref_clk_i);
    meas_valid_i = 1'b0;
    @(negedge ref_clk_i);
    `CHK(cap_flag, ec, "capacity flag")
    `CHK(sd_flag, es, "shutdown flag")
    `CHK(irq, ei, "irq pulse")
    `CHK(soc_zero, ez, "soc zero")
    `CHK(full_o, cap + 16'h03e8, "full charge value")
    @(negedge ref_clk_i);
    `CHK(pin, ec, "low battery pin")
    `CHK(irq, 1'b0, "irq length")
  endtask

  // one sense sample, estimate checked one edge after the take
  task automatic sense(input logic signed [15:0] s, input logic [31:0] exp);
    sense_i = s;
    sense_valid_i = 1'b1;
    @(negedge ref_clk_i);
    sense_valid_i = 1'b0;
    @(negedge ref_clk_i);
    `CHK(est_o, exp, "charge estimate")
  endtask

  task automatic cal(input logic sel, input logic [31:0] w);
    cal_select_i = sel;
    cal_word_i = w;
    cal_write_i = 1'b1;
    @(negedge ref_clk_i);
    cal_write_i = 1'b0;
    @(negedge ref_clk_i);
  endtask

  task automatic test_cal();
    `CHK(gain_o, 32'h00000000, "gain reset")
    cal(1'b0, 32'h84a00000);
    cal(1'b1, 32'h7f812345);
    `CHK(gain_o, 32'h84a00000, "gain word")
    `CHK(delta_o, 32'h7f812345, "delta word")
  endtask

  // accumulate up, floor at zero on a large discharge, then up again
  task automatic test_sense();
    sense(16'sh0005, 32'h00000005);
    sense(16'sh0007, 32'h0000000c);
    sense(-16'sh0014, 32'h00000000);
    sense(16'sh0009, 32'h00000009);
  endtask

  // below, equal (holds), above threshold, back to back at 3 cycles
  task automatic test_cap();
    meas(16'h0032, 16'h0d48, 1'b1, 1'b0, 1'b0, 1'b0);
    meas(16'h0064, 16'h0d48, 1'b1, 1'b0, 1'b0, 1'b0);
    meas(16'h0096, 16'h0d48, 1'b0, 1'b0, 1'b0, 1'b0);
    meas(16'h0064, 16'h0d48, 1'b0, 1'b0, 1'b0, 1'b0);
    low_pin_enable_i = 1'b0;
    meas(16'h0032, 16'h0d48, 1'b0, 1'b0, 1'b0, 1'b0);
    low_pin_enable_i = 1'b1;
    meas(16'h0032, 16'h0d48, 1'b1, 1'b0, 1'b0, 1'b0);
  endtask

  // hysteresis band: set below set level, hold inside band, clear above
  task automatic test_sd();
    meas(16'h0096, 16'h0b54, 1'b0, 1'b1, 1'b1, 1'b0);
    meas(16'h0096, 16'h0c80, 1'b0, 1'b1, 1'b0, 1'b0);
    meas(16'h0096, 16'h0ce4, 1'b0, 1'b1, 1'b0, 1'b0);
    meas(16'h0096, 16'h0d48, 1'b0, 1'b0, 1'b1, 1'b0);
    `CHK(irq_count, 8'h02, "irq count")
    `CHK(flag_at_irq, 1'b0, "flag at last irq")
  endtask

  // at the final voltage the estimate is forced to zero
  task automatic test_soc();
    meas(16'h0096, 16'h0af0, 1'b0, 1'b1, 1'b1, 1'b1);
    repeat (3) @(negedge ref_clk_i);
    `CHK(est_o, 32'h00000000, "estimate at final voltage")
    meas(16'h0096, 16'h0af1, 1'b0, 1'b1, 1'b0, 1'b0);
  endtask

  // cut a hang short well inside the run budget
  initial begin
    #(20000 * 25);
    errors++;
    finish_test();
  end

  initial begin
    repeat (8) @(negedge ref_clk_i);
    reset_i = 1'b0;
    `CHK(cap_flag, 1'b0, "flag after reset")
    `CHK(est_o, 32'h00000000, "estimate after reset")
    test_cal();
    test_sense();
    test_cap();
    test_sd();
    test_soc();
    finish_test();
  end
endmodule

/* File: pkg/blf_pkg.sv */
/*
 * blf_pkg: constants shared by the battery level flag logic.
 * assumes the measurement front end delivers unsigned mAh / mV words.
 */
package blf_pkg;
  localparam int CAP_W = 16;              // capacity width, mAh
  localparam int VOLT_W = 16;             // cell voltage width, mV
  localparam int CHG_W = 32;              // charge accumulator width
  localparam int F4_W = 32;               // four-byte calibration word
  localparam int F4_EXP_MSB = 31;         // biased exponent field top bit
  localparam int F4_EXP_LSB = 24;         // biased exponent field low bit
  localparam int F4_SIGN_BIT = 23;        // mantissa sign bit
  localparam int F4_MANT_MSB = 22;        // mantissa field top bit
  localparam int F4_EXP_BIAS = 128;       // exponent bias, 2^(e-128)
  localparam logic [CAP_W-1:0] CAP_LOW_RST = 16'h0000;
  localparam logic [VOLT_W-1:0] SOC_ZERO = 16'h0000;
  localparam logic [F4_W-1:0] GAIN_CAL_RST = 32'h00000000;
  localparam logic [F4_W-1:0] DELTA_CAL_RST = 32'h00000000;
  localparam int IRQ_PULSE_CYC = 1;       // interrupt pulse length, cycles
  typedef enum logic [1:0] {
    BLF_IDLE = 2'b00,
    BLF_EVAL = 2'b01,
    BLF_REPORT = 2'b10
  } blf_state_t;
endpackage

/* File: rtl/blf_charge_acc.sv */
/*
 * blf_charge_acc: coulomb accumulator for the flag logic.
 * assumes sense samples are signed, one per sample strobe, same clock.
 */
`timescale 1ns/1ps
module blf_charge_acc #(
  parameter int CHG_W = blf_pkg::CHG_W,
  parameter int SAMPLE_W = 16
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic sample_i,
  input wire logic signed [SAMPLE_W-1:0] sense_i,
  input wire logic load_i,
  input wire logic [CHG_W-1:0] load_value_i,
  output logic [CHG_W-1:0] charge_o
);
  logic [CHG_W-1:0] acc;
  logic [CHG_W-1:0] next_acc;
  logic [CHG_W-1:0] sense_ext;

  // sign-extend the sample; negative sense current is discharge
  assign sense_ext = {{(CHG_W-SAMPLE_W){sense_i[SAMPLE_W-1]}}, sense_i};

  // accumulate each sample unless load_i is high; floored at zero so an empty cell never wraps
  always_comb begin
    next_acc = acc;
    if (load_i) begin
      next_acc = load_value_i;
    end else if (sample_i) begin
      if (sense_i < 0 && acc < (~sense_ext + 1'b1)) begin
        next_acc = '0;
      end else begin
        next_acc = acc + sense_ext;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      acc <= '0;
    end else begin
      acc <= next_acc;
    end
  end

  assign charge_o = acc;

  a_acc_hold: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !sample_i && !load_i |=> acc == $past(acc))
    else $error("accumulator moved without a sample");
endmodule

/* File: rtl/blf_flag_logic.sv */
/*
 * blf_flag_logic: low-capacity and shutdown-warning flag logic.
 * assumes measurement strobes and config come from same-clock logic.
 */
// Behaviour
// - set capacity flag below capacity threshold
// - clear capacity flag above capacity threshold
// - low battery pin follows capacity flag
// - capacity flag and pin need enable bit
// - set shutdown flag below set voltage, interrupt
// - clear shutdown flag above clear voltage only
// - interrupt also on shutdown flag clear
// - charge state zero at final voltage
// - integrate sensed charge into charge estimate
// - full charge capacity from full cell estimate
// - calibration held in non-IEEE four-byte form
`timescale 1ns/1ps
module blf_flag_logic #(
  parameter int CAP_W = blf_pkg::CAP_W,
  parameter int VOLT_W = blf_pkg::VOLT_W,
  parameter int CHG_W = blf_pkg::CHG_W,
  parameter int SAMPLE_W = 16
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic meas_valid_i,
  input wire logic [CAP_W-1:0] left_charge_value_i,
  input wire logic [VOLT_W-1:0] cell_voltage_i,
  input wire logic [CAP_W-1:0] full_cell_estimate_i,
  input wire logic [CAP_W-1:0] capacity_low_threshold_i,
  input wire logic [VOLT_W-1:0] shutdown_set_voltage_i,
  input wire logic [VOLT_W-1:0] shutdown_clear_voltage_i,
  input wire logic [VOLT_W-1:0] final_voltage_i,
  input wire logic low_pin_enable_i,
  input wire logic sense_valid_i,
  input wire logic signed [SAMPLE_W-1:0] sense_i,
  input wire logic cal_write_i,
  input wire logic cal_select_i,
  input wire logic [blf_pkg::F4_W-1:0] cal_word_i,
  output logic capacity_low_flag_o,
  output logic shutdown_warning_flag_o,
  output logic low_battery_pin_o,
  output logic charge_state_irq_o,
  output logic soc_zero_o,
  output logic [CAP_W-1:0] full_cell_charge_value_o,
  output logic [CHG_W-1:0] charge_estimate_o,
  output logic [blf_pkg::F4_W-1:0] coulomb_gain_cal_o,
  output logic [blf_pkg::F4_W-1:0] coulomb_delta_cal_o
);
  blf_pkg::blf_state_t state;
  blf_pkg::blf_state_t next_state;
  logic [CAP_W-1:0] cap_sample;
  logic [CAP_W-1:0] next_cap_sample;
  logic [VOLT_W-1:0] volt_sample;
  logic [VOLT_W-1:0] next_volt_sample;
  logic [CAP_W-1:0] full_sample;
  logic [CAP_W-1:0] next_full_sample;
  logic cap_flag;
  logic next_cap_flag;
  logic sd_flag;
  logic next_sd_flag;
  logic pin;
  logic next_pin;
  logic irq;
  logic next_irq;
  logic soc_zero;
  logic next_soc_zero;
  logic [CAP_W-1:0] full_value;
  logic [CAP_W-1:0] next_full_value;
  logic [blf_pkg::F4_W-1:0] gain_cal;
  logic [blf_pkg::F4_W-1:0] next_gain_cal;
  logic [blf_pkg::F4_W-1:0] delta_cal;
  logic [blf_pkg::F4_W-1:0] next_delta_cal;
  logic [CHG_W-1:0] charge_acc;
  logic [CHG_W-1:0] charge_out;
  logic acc_load;

  // reload the integrator to zero once the cell hits its final voltage,
  // so integration restarts from an empty cell rather than drifting
  assign acc_load = soc_zero;

  blf_charge_acc #(
    .CHG_W(CHG_W),
    .SAMPLE_W(SAMPLE_W)
  ) u_acc (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .sample_i(sense_valid_i),
    .sense_i(sense_i),
    .load_i(acc_load),
    .load_value_i({CHG_W{1'b0}}),
    .charge_o(charge_acc)
  );

  // sequencer: capture a measurement, evaluate, then report
  always_comb begin
    next_state = state;
    next_cap_sample = cap_sample;
    next_volt_sample = volt_sample;
    next_full_sample = full_sample;
    case (state)
      blf_pkg::BLF_IDLE: begin
        if (meas_valid_i) begin
          next_cap_sample = left_charge_value_i;
          next_volt_sample = cell_voltage_i;
          next_full_sample = full_cell_estimate_i;
          next_state = blf_pkg::BLF_EVAL;
        end
      end
      blf_pkg::BLF_EVAL: begin
        next_state = blf_pkg::BLF_REPORT;
      end
      blf_pkg::BLF_REPORT: begin
        next_state = blf_pkg::BLF_IDLE;
      end
      default: begin
        next_state = blf_pkg::BLF_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state <= blf_pkg::BLF_IDLE;
      cap_sample <= '0;
      volt_sample <= '0;
      full_sample <= '0;
    end else begin
      state <= next_state;
      cap_sample <= next_cap_sample;
      volt_sample <= next_volt_sample;
      full_sample <= next_full_sample;
    end
  end

  // threshold evaluation; equality holds the flag where it was, which
  // keeps it from chattering on a reading parked at the threshold
  always_comb begin
    next_cap_flag = cap_flag;
    next_sd_flag = sd_flag;
    next_pin = pin;
    next_irq = 1'b0;
    next_soc_zero = soc_zero;
    next_full_value = full_value;
    if (!low_pin_enable_i) begin
      next_cap_flag = 1'b0;
      next_pin = 1'b0;
    end
    if (state == blf_pkg::BLF_EVAL) begin
      if (low_pin_enable_i) begin
        if (cap_sample < capacity_low_threshold_i) begin
          next_cap_flag = 1'b1;
        end else if (cap_sample > capacity_low_threshold_i) begin
          next_cap_flag = 1'b0;
        end
      end
      if (!sd_flag && volt_sample < shutdown_set_voltage_i) begin
        next_sd_flag = 1'b1;
        next_irq = 1'b1;
      end else if (sd_flag && volt_sample > shutdown_clear_voltage_i) begin
        next_sd_flag = 1'b0;
        next_irq = 1'b1;
      end
      next_soc_zero = (volt_sample <= final_voltage_i);
      next_full_value = full_sample;
    end
    if (state == blf_pkg::BLF_REPORT && low_pin_enable_i) begin
      next_pin = cap_flag;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      cap_flag <= 1'b0;
      sd_flag <= 1'b0;
      pin <= 1'b0;
      irq <= 1'b0;
      soc_zero <= 1'b0;
      full_value <= blf_pkg::CAP_LOW_RST;
    end else begin
      cap_flag <= next_cap_flag;
      sd_flag <= next_sd_flag;
      pin <= next_pin;
      irq <= next_irq;
      soc_zero <= next_soc_zero;
      full_value <= next_full_value;
    end
  end

  // calibration words are stored as given: exponent in the top byte,
  // sign at bit 23, not an IEEE encoding, so no conversion is done here
  always_comb begin
    next_gain_cal = gain_cal;
    next_delta_cal = delta_cal;
    if (cal_write_i && !cal_select_i) begin
      next_gain_cal = cal_word_i;
    end
    if (cal_write_i && cal_select_i) begin
      next_delta_cal = cal_word_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      gain_cal <= blf_pkg::GAIN_CAL_RST;
      delta_cal <= blf_pkg::DELTA_CAL_RST;
      charge_out <= '0;
    end else begin
      gain_cal <= next_gain_cal;
      delta_cal <= next_delta_cal;
      charge_out <= soc_zero ? '0 : charge_acc;
    end
  end

  assign capacity_low_flag_o = cap_flag;
  assign shutdown_warning_flag_o = sd_flag;
  assign low_battery_pin_o = pin;
  assign charge_state_irq_o = irq;
  assign soc_zero_o = soc_zero;
  assign full_cell_charge_value_o = full_value;
  assign charge_estimate_o = charge_out;
  assign coulomb_gain_cal_o = gain_cal;
  assign coulomb_delta_cal_o = delta_cal;

  sequence s_low_eval;
    state == blf_pkg::BLF_EVAL && low_pin_enable_i
      && cap_sample < capacity_low_threshold_i;
  endsequence

  sequence s_sd_clear_eval;
    state == blf_pkg::BLF_EVAL && sd_flag
      && volt_sample > shutdown_clear_voltage_i;
  endsequence

  a_cap_set: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    s_low_eval |=> cap_flag)
    else $error("capacity flag not set below threshold");

  a_cap_clear: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    state == blf_pkg::BLF_EVAL && cap_sample > capacity_low_threshold_i
    |=> !cap_flag)
    else $error("capacity flag not cleared above threshold");

  a_pin_follow: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    s_low_eval |=> ##1 pin)
    else $error("pin did not follow capacity flag");

  a_enable_gate: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !low_pin_enable_i |=> !cap_flag && !pin)
    else $error("capacity flag active while disabled");

  a_sd_set_irq: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    state == blf_pkg::BLF_EVAL && !sd_flag
      && volt_sample < shutdown_set_voltage_i
    |=> sd_flag && irq ##1 !irq)
    else $error("shutdown set without flag or irq");

  a_sd_hyst: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    $fell(sd_flag) |-> $past(volt_sample) > shutdown_clear_voltage_i)
    else $error("shutdown flag cleared below clear voltage");

  a_sd_clr_irq: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    s_sd_clear_eval |=> !sd_flag && irq)
    else $error("no irq on shutdown clear");

  a_soc_zero: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    state == blf_pkg::BLF_EVAL && volt_sample <= final_voltage_i
    |=> soc_zero ##1 charge_out == '0)
    else $error("charge state not zero at final voltage");

  a_full_value: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    state == blf_pkg::BLF_EVAL |=> full_value == $past(full_sample))
    else $error("full charge value not updated");

  a_meas_eval: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    state == blf_pkg::BLF_IDLE && meas_valid_i
    |=> state == blf_pkg::BLF_EVAL ##1 state == blf_pkg::BLF_REPORT)
    else $error("measurement not evaluated");
endmodule
